// ---- hw/clk_ratio_ctrl.sv ----
// Top: system and subsystem clock ratio control with Avalon-MM registers
// ========================================================
// What this block does
// - Main clock divided by 4, 8, 16 or 32 from ratio bits 0-1.
// - Ratio bits apply only in watch mode or on direct transfer; frequency bits apply at once.
// - Active-mode writes keep the old ratio until watch then active.
// - Subactive-mode writes apply on entering active via watch or directly.
// - After reset or stop cancel, strap high gives /4, low gives /32.
// - Subsystem clock divided by 4 or 8 from bit 2 of select A.
// - Subsystem ratio bit applies immediately after write.
// - Watch entered by stop with watch select, or stop/standby in subactive.
// - Subactive instruction cycle is 244 us or 122 us by the sub ratio bit.
//
// Local design decision: the Avalon-MM interface to the registers.
module clk_ratio_ctrl
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // Avalon-MM slave
    input  wire logic [11:0]             avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    // Core mode requests and pins
    input  wire clk_ratio_pkg::mode_req_s mode_req,
    input  wire logic                    ratio_strap,
    // Clock enables and status out
    output logic                         main_clk_tick,
    output logic                         sub_clk_tick,
    output clk_ratio_pkg::pwr_mode_e     pwr_mode,
    output logic [3:0]                   freq_bits
);

    // ========================================================
    // Registers
    logic [3:0]               sel_a_r;
    logic [3:0]               sel_b_r;
    logic [1:0]               ratio_applied_r;
    logic                     watch_select_bit_r;
    logic                     low_speed_r;
    logic                     direct_r;
    logic                     pending_r;
    logic                     strap_load_r;
    logic                     ack_r;
    clk_ratio_pkg::pwr_mode_e mode_r;
    clk_ratio_pkg::pwr_mode_e mode_nxt;
    logic                     main_tick_w;
    logic                     sub_tick_w;
    logic [9:0]               idx;
    logic                     wr_en;
    logic                     main_run;

    assign idx   = avs_address[11:2];
    assign wr_en = avs_write && !ack_r && avs_byteenable[0];

    // ========================================================
    // Bus handshake: one wait cycle, answer on the second edge
    // Waitrequest is a flop of its own so the port stays registered
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ack_r           <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            ack_r           <= (avs_read || avs_write) && !ack_r;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
        end
    end

    // Writes land on the first cycle; bus data stays held until ack
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sel_a_r            <= clk_ratio_pkg::SEL_A_RST;
            sel_b_r            <= clk_ratio_pkg::SEL_B_RST;
            watch_select_bit_r <= 1'b0;
            low_speed_r        <= 1'b0;
            direct_r           <= 1'b0;
        end
        else
        begin
            if (wr_en && idx == clk_ratio_pkg::IDX_SEL_A)
                sel_a_r <= avs_writedata[3:0];
            if (wr_en && idx == clk_ratio_pkg::IDX_SEL_B)
                sel_b_r <= avs_writedata[3:0];
            if (wr_en && idx == clk_ratio_pkg::IDX_MODE_CTRL)
            begin
                watch_select_bit_r <= avs_writedata[0];
                low_speed_r        <= avs_writedata[1];
                // Direct transfer only settable in subactive
                direct_r <= avs_writedata[2]
                    && (mode_r == clk_ratio_pkg::MODE_SUBACTIVE);
            end
            else if (mode_r == clk_ratio_pkg::MODE_ACTIVE)
                direct_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && !ack_r)
        begin
            avs_readdata <= 32'h0000_0000;
            case (idx)
                clk_ratio_pkg::IDX_SEL_A:
                    avs_readdata[3:0] <= sel_a_r;
                clk_ratio_pkg::IDX_SEL_B:
                    avs_readdata[3:0] <= sel_b_r;
                clk_ratio_pkg::IDX_MODE_CTRL:
                    avs_readdata[2:0] <= {direct_r, low_speed_r,
                                          watch_select_bit_r};
                clk_ratio_pkg::IDX_STATUS:
                    avs_readdata[6:0] <= {pending_r, ratio_applied_r,
                                          1'b0, mode_r};
                default:
                    avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ========================================================
    // Power mode sequencing
    always_comb
    begin
        mode_nxt = mode_r;
        case (mode_r)
            clk_ratio_pkg::MODE_ACTIVE:
                if (mode_req.stop_instr)
                    mode_nxt = watch_select_bit_r
                        ? clk_ratio_pkg::MODE_WATCH
                        : clk_ratio_pkg::MODE_STOP;
                else if (mode_req.standby_instruction)
                    mode_nxt = clk_ratio_pkg::MODE_STANDBY;
            clk_ratio_pkg::MODE_STANDBY:
                if (mode_req.wake_irq)
                    mode_nxt = clk_ratio_pkg::MODE_ACTIVE;
            clk_ratio_pkg::MODE_STOP:
                if (mode_req.stop_cancel)
                    mode_nxt = clk_ratio_pkg::MODE_ACTIVE;
            clk_ratio_pkg::MODE_WATCH:
                if (mode_req.wake_irq)
                    mode_nxt = low_speed_r
                        ? clk_ratio_pkg::MODE_SUBACTIVE
                        : clk_ratio_pkg::MODE_ACTIVE;
            clk_ratio_pkg::MODE_SUBACTIVE:
                if (mode_req.stop_instr || mode_req.standby_instruction)
                    mode_nxt = (direct_r && !low_speed_r)
                        ? clk_ratio_pkg::MODE_ACTIVE
                        : clk_ratio_pkg::MODE_WATCH;
            default:
                mode_nxt = clk_ratio_pkg::MODE_ACTIVE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            mode_r <= clk_ratio_pkg::MODE_ACTIVE;
        else
            mode_r <= mode_nxt;
    end

    // ========================================================
    // Main ratio: strap after reset, shadowed until watch or direct transfer
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            strap_load_r <= 1'b1;
        else
            strap_load_r <= (mode_r == clk_ratio_pkg::MODE_STOP)
                && mode_req.stop_cancel;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ratio_applied_r <= clk_ratio_pkg::RATIO_DIV32;
        else if (strap_load_r)
            ratio_applied_r <= ratio_strap
                ? clk_ratio_pkg::RATIO_DIV4
                : clk_ratio_pkg::RATIO_DIV32;
        else if (mode_r == clk_ratio_pkg::MODE_WATCH)
            // Main clock is stopped here, so the swap is glitch free
            ratio_applied_r <= sel_b_r[1:0];
        else if (mode_r == clk_ratio_pkg::MODE_SUBACTIVE
                 && mode_nxt == clk_ratio_pkg::MODE_ACTIVE)
            ratio_applied_r <= sel_b_r[1:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            pending_r <= 1'b0;
        else
            pending_r <= sel_b_r[1:0] != ratio_applied_r;
    end

    // ========================================================
    // Dividers
    assign main_run = mode_r == clk_ratio_pkg::MODE_ACTIVE
        || mode_r == clk_ratio_pkg::MODE_STANDBY;

    clk_ratio_div u_main_div
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (main_run),
        // 2^(ratio+2)-1: /4, /8, /16, /32
        .max_cnt (5'(clk_ratio_pkg::DIV_MAX
                  >> (2'd3 - ratio_applied_r))),
        .tick    (main_tick_w)
    );

    clk_ratio_div u_sub_div
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (!sel_a_r[clk_ratio_pkg::SEL_A_SUBSTOP]
                  || mode_r != clk_ratio_pkg::MODE_STOP),
        .max_cnt ({2'b00,
                   sel_a_r[clk_ratio_pkg::SEL_A_SUBRATIO]
                   == clk_ratio_pkg::SUB_DIV4
                   ? clk_ratio_pkg::SUB_MAX4
                   : clk_ratio_pkg::SUB_MAX8}),
        .tick    (sub_tick_w)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            main_clk_tick <= 1'b0;
            sub_clk_tick  <= 1'b0;
            pwr_mode      <= clk_ratio_pkg::MODE_ACTIVE;
            freq_bits     <= 4'h0;
        end
        else
        begin
            main_clk_tick <= main_tick_w;
            sub_clk_tick  <= sub_tick_w;
            pwr_mode      <= mode_r;
            // Frequency bits pass at once to tone/timebase logic
            freq_bits <= {sel_b_r[clk_ratio_pkg::SEL_B_FREQ_D],
                          sel_b_r[clk_ratio_pkg::SEL_B_FREQ_C],
                          sel_a_r[clk_ratio_pkg::SEL_A_FREQ_B],
                          sel_a_r[clk_ratio_pkg::SEL_A_FREQ_A]};
        end
    end

endmodule

// ---- hw/clk_ratio_pkg.sv ----
// Package: register map, field layout and encodings of the clock ratio block
package clk_ratio_pkg;

    // ========================================================
    // Register map (printed indices, byte address = 4 * index)
    localparam logic [9:0] IDX_SEL_A      = 10'h029;
    localparam logic [9:0] IDX_SEL_B      = 10'h02A;
    localparam logic [9:0] IDX_MODE_CTRL  = 10'h040;
    localparam logic [9:0] IDX_STATUS     = 10'h041;
    localparam int         ADDR_W         = 12;

    // ========================================================
    // Field positions
    localparam int SEL_A_FREQ_A   = 0;
    localparam int SEL_A_FREQ_B   = 1;
    localparam int SEL_A_SUBRATIO = 2;
    localparam int SEL_A_SUBSTOP  = 3;
    localparam int SEL_B_RATIO_LO = 0;
    localparam int SEL_B_FREQ_C   = 2;
    localparam int SEL_B_FREQ_D   = 3;

    // ========================================================
    // Reset values
    localparam logic [3:0] SEL_A_RST = 4'h0;
    localparam logic [3:0] SEL_B_RST = 4'h0;

    // ========================================================
    // Ratio encodings: 00 /4, 01 /8, 10 /16, 11 /32
    localparam logic [1:0] RATIO_DIV4  = 2'h0;
    localparam logic [1:0] RATIO_DIV32 = 2'h3;
    localparam logic [4:0] DIV_MAX     = 5'h1F;

    // Subsystem ratio 0 -> /4 (122 us cycle), 1 -> /8 (244 us cycle)
    localparam logic       SUB_DIV4   = 1'b0;
    localparam logic [2:0] SUB_MAX4   = 3'h3;
    localparam logic [2:0] SUB_MAX8   = 3'h7;

    // ========================================================
    // Power modes
    typedef enum logic [2:0] {
        MODE_ACTIVE    = 3'b000,
        MODE_STANDBY   = 3'b001,
        MODE_STOP      = 3'b010,
        MODE_WATCH     = 3'b011,
        MODE_SUBACTIVE = 3'b100
    } pwr_mode_e;

    // Mode request pulses from the CPU core
    typedef struct packed {
        logic stop_instr;
        logic standby_instruction;
        logic wake_irq;
        logic stop_cancel;
    } mode_req_s;

    // Ratio state bundle, unused: the divider takes run and max_cnt instead
    typedef struct packed {
        logic       run;
        logic [1:0] ratio;
    } div_cfg_s;

endpackage

// ---- hw/clk_ratio_div.sv ----
// Leaf: programmable power-of-two clock enable divider
module clk_ratio_div
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Control
    input  wire logic       run,
    input  wire logic [4:0] max_cnt,
    // Output tick
    output logic            tick
);

    logic [4:0] cnt_r;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !run)
        begin
            cnt_r <= 5'h00;
            tick  <= 1'b0;
        end
        else if (cnt_r >= max_cnt)
        begin
            cnt_r <= 5'h00;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 5'h01;
            tick  <= 1'b0;
        end
    end

endmodule

// ---- test/clk_ratio_checker.sv ----
// Checker: timing properties on the clock ratio block ports
module clk_ratio_checker
(
    // Clock and reset
    input wire logic                     clk_sys,
    input wire logic                     rst_n,
    // Register bus
    input wire logic [11:0]              avs_address,
    input wire logic                     avs_read,
    input wire logic                     avs_write,
    input wire logic [31:0]              avs_writedata,
    input wire logic [3:0]               avs_byteenable,
    input wire logic [31:0]              avs_readdata,
    input wire logic                     avs_waitrequest,
    // Core requests and pins
    input wire clk_ratio_pkg::mode_req_s mode_req,
    input wire logic                     ratio_strap,
    // Clock enables and status
    input wire logic                     main_clk_tick,
    input wire logic                     sub_clk_tick,
    input wire clk_ratio_pkg::pwr_mode_e pwr_mode,
    input wire logic [3:0]               freq_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Helpers
    logic take_b;
    assign take_b = avs_write && avs_waitrequest && avs_byteenable[0]
        && avs_address[11:2] == clk_ratio_pkg::IDX_SEL_B;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ====
    // Properties
    AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus answer late");
    AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer held too long");
    AST_FREQ_B:
    assert property (take_b |-> ##2 freq_bits[3:2] == $past(
        avs_writedata[3:2], 2)) else $error("freq bits not applied");
    // Mode output lags the internal state by one flop: look two edges on
    AST_STOP_INSTR:
    assert property (pwr_mode == clk_ratio_pkg::MODE_ACTIVE
        && mode_req.stop_instr |-> ##2 pwr_mode inside
        {clk_ratio_pkg::MODE_WATCH, clk_ratio_pkg::MODE_STOP})
        else $error("stop not taken in active");
    AST_SUB_LEAVE:
    assert property (pwr_mode == clk_ratio_pkg::MODE_SUBACTIVE
        && (mode_req.stop_instr || mode_req.standby_instruction)
        |-> ##2 pwr_mode inside
        {clk_ratio_pkg::MODE_WATCH, clk_ratio_pkg::MODE_ACTIVE})
        else $error("subactive exit wrong");
    AST_CANCEL:
    assert property (pwr_mode == clk_ratio_pkg::MODE_STOP
        && mode_req.stop_cancel |-> ##2
        pwr_mode == clk_ratio_pkg::MODE_ACTIVE)
        else $error("stop cancel ignored");
    AST_STRAP_FAST:
    assert property (pwr_mode == clk_ratio_pkg::MODE_STOP
        && mode_req.stop_cancel && ratio_strap |-> ##[1:12] main_clk_tick
        ##1 !main_clk_tick[*3] ##1 main_clk_tick)
        else $error("strap high not divide by four");
    AST_DARK_MAIN:
    assert property (pwr_mode inside {clk_ratio_pkg::MODE_WATCH,
        clk_ratio_pkg::MODE_STOP, clk_ratio_pkg::MODE_SUBACTIVE}
        && pwr_mode == $past(pwr_mode) |-> !main_clk_tick)
        else $error("main tick while stopped");
    AST_SUB_GAP:
    assert property (sub_clk_tick |=> !sub_clk_tick[*3])
        else $error("sub tick too close");
endmodule

bind clk_ratio_ctrl clk_ratio_checker chk_i
(
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mode_req(mode_req), .ratio_strap(ratio_strap),
    .main_clk_tick(main_clk_tick), .sub_clk_tick(sub_clk_tick),
    .pwr_mode(pwr_mode), .freq_bits(freq_bits)
);

// ---- test/core_pins_model.sv ----
// Partner: core request pulses and strap pin facing the ratio block
module core_pins_model
(
    // Commands from the bench
    input  wire logic [3:0]          cmd,
    input  wire logic                strap_lvl,
    // Lines toward the block
    output clk_ratio_pkg::mode_req_s mode_req,
    output logic                     ratio_strap
);
    timeunit 1ns;
    timeprecision 1ps;
    // Board strap is a static level
    assign ratio_strap = strap_lvl;
    assign mode_req = clk_ratio_pkg::mode_req_s'(cmd);
endmodule

// ---- test/system_clock_divider_control_bench.sv ----
// Bench: register and power-mode sequences for the clock ratio block
module system_clock_divider_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Signals
    logic                     clk_sys = 1'b0;
    logic                     rst_n = 1'b0;
    logic [11:0]              avs_address = 12'h000;
    logic                     avs_read = 1'b0;
    logic                     avs_write = 1'b0;
    logic [31:0]              avs_writedata = 32'h0;
    logic [3:0]               avs_byteenable = 4'hF;
    logic [31:0]              avs_readdata;
    logic                     avs_waitrequest;
    logic [3:0]               cmd = 4'h0;
    logic                     strap_lvl = 1'b1;
    clk_ratio_pkg::mode_req_s mode_req;
    logic                     ratio_strap;
    logic                     main_clk_tick;
    logic                     sub_clk_tick;
    clk_ratio_pkg::pwr_mode_e pwr_mode;
    logic [3:0]               freq_bits;
    logic [31:0]              rd;
    logic [31:0]              n;
    int                       err_total = 0;
    int                       checked = 0;
    always #5 clk_sys = ~clk_sys;
    clk_ratio_ctrl uut
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mode_req(mode_req), .ratio_strap(ratio_strap),
        .main_clk_tick(main_clk_tick), .sub_clk_tick(sub_clk_tick),
        .pwr_mode(pwr_mode), .freq_bits(freq_bits)
    );
    core_pins_model core_i
    (
        .cmd(cmd), .strap_lvl(strap_lvl), .mode_req(mode_req),
        .ratio_strap(ratio_strap)
    );
    // ====
    // Tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task bus(input logic wr, input logic [9:0] idx, input logic [3:0] d,
             input logic [3:0] be);
        avs_address    <= {idx, 2'h0};
        avs_writedata  <= {28'h0, d};
        avs_byteenable <= be;
        avs_read       <= !wr;
        avs_write      <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        // Idle edge keeps strobes from being driven twice at once
        @(posedge clk_sys);
    endtask
    task rdchk(input logic [9:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 4'h0, 4'hF);
        chk(rd, exp);
    endtask
    task req(input logic [3:0] c);
        cmd <= c;
        @(posedge clk_sys);
        cmd <= 4'h0;
        repeat (6) @(posedge clk_sys);
    endtask
    function logic tk(input logic s);
        return s ? sub_clk_tick : main_clk_tick;
    endfunction
    task per(input logic s);
        n = 0;
        while (tk(s) !== 1'b1 && n < 80)
        begin
            @(posedge clk_sys);
            n++;
        end
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (tk(s) !== 1'b1 && n < 80);
    endtask
    task give_verdict;
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ====
    // Sequence
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        per(1'b0);
        chk(n, 32'h4);
        rdchk(clk_ratio_pkg::IDX_SEL_A, 32'h0);
        rdchk(clk_ratio_pkg::IDX_SEL_B, 32'h0);
        bus(1'b1, 10'h3FF, 4'hF, 4'hF);
        rdchk(10'h3FF, 32'h0);
        bus(1'b1, clk_ratio_pkg::IDX_SEL_B, 4'hD, 4'hE);
        rdchk(clk_ratio_pkg::IDX_SEL_B, 32'h0);
        bus(1'b1, clk_ratio_pkg::IDX_MODE_CTRL, 4'h1, 4'hF);
        for (int r = 0; r < 4; r++)
        begin
            bus(1'b1, clk_ratio_pkg::IDX_SEL_B, {2'h3, r[1:0]}, 4'hF);
            chk({30'h0, freq_bits[3:2]}, 32'h3);
            // Status: pending set except for r = 0, old ratio still applied
            rdchk(clk_ratio_pkg::IDX_STATUS, {25'h0, r != 0,
                  2'(r == 0 ? 0 : r - 1), 4'h0});
            per(1'b0);
            chk(n, (r == 0) ? 32'h4 : 32'h4 << (r - 1));
            req(4'h8);
            chk({29'h0, pwr_mode}, 32'h3);
            req(4'h2);
            per(1'b0);
            chk(n, 32'h4 << r);
        end
        bus(1'b1, clk_ratio_pkg::IDX_MODE_CTRL, 4'h3, 4'hF);
        req(4'h8);
        req(4'h2);
        chk({29'h0, pwr_mode}, 32'h4);
        bus(1'b1, clk_ratio_pkg::IDX_SEL_B, 4'hE, 4'hF);
        bus(1'b1, clk_ratio_pkg::IDX_MODE_CTRL, 4'h5, 4'hF);
        rdchk(clk_ratio_pkg::IDX_MODE_CTRL, 32'h5);
        req(4'h4);
        chk({29'h0, pwr_mode}, 32'h0);
        rdchk(clk_ratio_pkg::IDX_MODE_CTRL, 32'h1);
        per(1'b0);
        chk(n, 32'h10);
        bus(1'b1, clk_ratio_pkg::IDX_SEL_A, 4'h7, 4'hF);
        chk({30'h0, freq_bits[1:0]}, 32'h3);
        per(1'b1);
        chk(n, 32'h8);
        bus(1'b1, clk_ratio_pkg::IDX_SEL_A, 4'h3, 4'hF);
        per(1'b1);
        chk(n, 32'h4);
        bus(1'b1, clk_ratio_pkg::IDX_MODE_CTRL, 4'h0, 4'hF);
        for (int s = 0; s < 2; s++)
        begin
            strap_lvl <= s[0];
            req(4'h8);
            chk({29'h0, pwr_mode}, 32'h2);
            req(4'h1);
            per(1'b0);
            chk(n, s ? 32'h4 : 32'h20);
        end
        give_verdict;
    end
    // Whole run needs about 450 cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        give_verdict;
    end
endmodule
